//--- rtl/rdt_timeout_status.sv
// Receive DMA channel time-out counter, stop status and APB registers
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns

module rdt_timeout_status
(
    input wire logic MCLK, // System clock, 20 MHz
    input wire logic RSTN, // Asynchronous reset, active low
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB write when high
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error on unmapped address
    input wire logic RX_BYTE_XFER, // Pulse: channel moved one byte
    input wire logic SOF_PULSE, // Pulse: USB start of frame
    input wire logic RX_ERROR, // Pulse: UART receive error
    input wire logic BUFFERS_FULL, // Level: both buffers and FIFO full
    output logic CHANNEL_ENABLE, // Level: channel enable bit
    output logic CHANNEL_ACTIVE, // Level: channel may transfer
    output logic TIMEOUT_FLAG, // Level: time-out flag
    output logic OVERRUN_FLAG, // Level: overrun flag
    output logic IRQ // Level: unmasked interrupt pending
);

    rdt_pkg::rdt_state_t s;
    rdt_pkg::rdt_state_t next_s;

    logic access;
    logic wr;
    logic rd;
    logic setup_rd;
    logic active;
    logic counting;
    logic byte_ev;
    logic sof_ev;
    logic expire;
    logic err_ev;
    logic [rdt_pkg::IRQ_W-1:0] irq_set;
    // Register decode and software strobes
    logic hit_status;
    logic hit_control;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic wr_status;
    logic wr_control;
    logic wr_mask;
    logic rd_irq_status;
    logic clr_overrun;
    logic clr_timeout;
    logic restart;
    // Stop handling
    logic expire_stop;
    logic fw_stop;
    logic stop_irq;

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic addr_valid(input logic [7:0] a);
        return addr_hit(a, rdt_pkg::ADDR_STATUS)
            || addr_hit(a, rdt_pkg::ADDR_CONTROL)
            || addr_hit(a, rdt_pkg::ADDR_IRQ_STATUS)
            || addr_hit(a, rdt_pkg::ADDR_IRQ_MASK)
            || addr_hit(a, rdt_pkg::ADDR_COUNT);
    endfunction

    function automatic logic [31:0] status_word(
        input rdt_pkg::rdt_state_t st);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[rdt_pkg::OVERRUN_BIT] = st.overrun_flag;
        w[rdt_pkg::TIMEOUT_BIT] = st.timeout_flag;
        w[rdt_pkg::TVAL_MSB:rdt_pkg::TVAL_LSB] = st.tval;
        w[rdt_pkg::TEN_BIT] = st.timeout_counter_enable;
        return w;
    endfunction

    function automatic logic [31:0] read_mux(
        input logic [7:0] a,
        input rdt_pkg::rdt_state_t st);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (addr_hit(a, rdt_pkg::ADDR_STATUS))
        begin
            w = status_word(st);
        end
        else if (addr_hit(a, rdt_pkg::ADDR_CONTROL))
        begin
            w[rdt_pkg::IRQ_EN_BIT] = st.irq_en;
            w[rdt_pkg::CHAN_EN_BIT] = st.chan_en;
        end
        else if (addr_hit(a, rdt_pkg::ADDR_IRQ_STATUS))
        begin
            w[rdt_pkg::IRQ_W-1:0] = st.irq_stat;
        end
        else if (addr_hit(a, rdt_pkg::ADDR_IRQ_MASK))
        begin
            w[rdt_pkg::IRQ_W-1:0] = st.irq_mask;
        end
        else if (addr_hit(a, rdt_pkg::ADDR_COUNT))
        begin
            w[rdt_pkg::CNT_MSB:rdt_pkg::CNT_LSB] = st.cnt;
            w[rdt_pkg::SEEN_BIT] = st.byte_seen;
            w[rdt_pkg::HALT_BIT] = st.halted;
        end
        return w;
    endfunction

    // Write-one-to-clear: a zero written leaves the flag as it was
    function automatic logic w1c(input logic flag, input logic clr);
        return flag && !clr;
    endfunction

    // Byte reload has priority over a frame step in the same cycle
    function automatic logic [rdt_pkg::TVAL_W-1:0] count_next(
        input logic [rdt_pkg::TVAL_W-1:0] cnt,
        input logic [rdt_pkg::TVAL_W-1:0] tval,
        input logic reload,
        input logic step);
        logic [rdt_pkg::TVAL_W-1:0] c;
        c = cnt;
        if (reload)
        begin
            c = tval;
        end
        else if (step)
        begin
            c = cnt - rdt_pkg::CNT_ONE;
        end
        return c;
    endfunction

    // Interrupt status bits raised by one expiry
    function automatic logic [rdt_pkg::IRQ_W-1:0] expiry_irq(
        input logic full);
        logic [rdt_pkg::IRQ_W-1:0] b;
        b = '0;
        b[rdt_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
        b[rdt_pkg::IRQ_OVERRUN_BIT] = full;
        return b;
    endfunction

    // Bus phases; reads are captured in setup so PRDATA comes from a flop
    assign access = PSEL && PENABLE;
    assign wr = access && PWRITE;
    assign rd = access && !PWRITE;
    assign setup_rd = PSEL && !PENABLE && !PWRITE;

    // One address decode feeds the write strobes and the read clear
    assign hit_status = addr_hit(PADDR, rdt_pkg::ADDR_STATUS);
    assign hit_control = addr_hit(PADDR, rdt_pkg::ADDR_CONTROL);
    assign hit_irq_status = addr_hit(PADDR, rdt_pkg::ADDR_IRQ_STATUS);
    assign hit_irq_mask = addr_hit(PADDR, rdt_pkg::ADDR_IRQ_MASK);
    assign wr_status = wr && hit_status;
    assign wr_control = wr && hit_control;
    assign wr_mask = wr && hit_irq_mask;
    assign rd_irq_status = rd && hit_irq_status;
    assign clr_overrun = wr_status && PWDATA[rdt_pkg::OVERRUN_BIT];
    assign clr_timeout = wr_status && PWDATA[rdt_pkg::TIMEOUT_BIT];
    assign restart = wr_control && PWDATA[rdt_pkg::CHAN_EN_BIT];

    // Channel events
    assign active = s.chan_en && !s.halted;
    assign byte_ev = RX_BYTE_XFER && active;
    assign err_ev = RX_ERROR && active;
    assign counting = s.timeout_counter_enable
                      && s.chan_en
                      && s.byte_seen
                      && !s.halted;
    assign sof_ev = SOF_PULSE && counting && !byte_ev;
    // A count of one reaches zero on this pulse; zero is already there
    assign expire = sof_ev && (s.cnt <= rdt_pkg::CNT_ONE);

    // Enable falls on expiry only with interrupts on; firmware may drop it
    assign expire_stop = expire && s.irq_en;
    assign fw_stop = wr_control && !PWDATA[rdt_pkg::CHAN_EN_BIT];
    assign stop_irq = s.chan_en && s.irq_en
                      && (expire_stop || fw_stop);

    // Stop causes as the flag pair (time-out, overrun) shows them:
    //   receive error          0 0  enable kept, no interrupt from here
    //   expiry, starved        1 0  the receiver ran out of data
    //   expiry, host stalled   1 1  both buffers and the FIFO were full
    // An error and an expiry in the same cycle report as the expiry.
    // A zero limit expires on the first frame once counting runs.
    // With counting off no frame steps the value, though a byte still reloads it; nothing times out.

    always_comb
    begin
        next_s = s;
        irq_set = '0;

        // Read data is taken one cycle early so it leaves from a flop
        if (setup_rd)
        begin
            next_s.prdata = read_mux(PADDR, s);
        end

        // Software side first, so hardware sets below win over clears
        if (wr_status)
        begin
            next_s.overrun_flag = w1c(s.overrun_flag, clr_overrun);
            next_s.timeout_flag = w1c(s.timeout_flag, clr_timeout);
            next_s.tval =
                PWDATA[rdt_pkg::TVAL_MSB:rdt_pkg::TVAL_LSB];
            next_s.timeout_counter_enable =
                PWDATA[rdt_pkg::TEN_BIT];
        end

        if (wr_control)
        begin
            next_s.irq_en = PWDATA[rdt_pkg::IRQ_EN_BIT];
            next_s.chan_en = PWDATA[rdt_pkg::CHAN_EN_BIT];
        end

        // Writing enable high starts a fresh transaction
        if (restart)
        begin
            next_s.halted = 1'b0;
            next_s.byte_seen = 1'b0;
        end

        if (wr_mask)
        begin
            next_s.irq_mask = PWDATA[rdt_pkg::IRQ_W-1:0];
        end

        if (rd_irq_status)
        begin
            next_s.irq_stat = '0;
        end

        // Down counter
        next_s.cnt = count_next(s.cnt, s.tval, byte_ev, sof_ev && !expire);
        if (byte_ev)
        begin
            next_s.byte_seen = 1'b1;
        end

        // Receive error halts with both flags at zero and no interrupt
        if (err_ev)
        begin
            next_s.halted = 1'b1;
            next_s.timeout_flag = 1'b0;
            next_s.overrun_flag = 1'b0;
        end

        if (expire)
        begin
            next_s.cnt = '0;
            next_s.halted = 1'b1;
            next_s.timeout_flag = 1'b1;
            // Full buffers mean the host stalled, otherwise starvation
            next_s.overrun_flag = BUFFERS_FULL;
            irq_set = expiry_irq(BUFFERS_FULL);
        end

        // With interrupts off the enable stays up for the next run
        if (expire_stop)
        begin
            next_s.chan_en = 1'b0;
        end

        // Falling enable with interrupts on, by hardware or firmware, is the stop event
        irq_set[rdt_pkg::IRQ_STOP_BIT] = stop_irq;

        // Disabled channel forgets its first-byte condition
        if (!next_s.chan_en)
        begin
            next_s.byte_seen = 1'b0;
        end

        // Hardware sets are merged last and win over a read clear
        next_s.irq_stat = next_s.irq_stat | irq_set;
    end

    // Reset loads constants only
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s <= '{
                chan_en: 1'b0,
                irq_en: 1'b0,
                overrun_flag: 1'b0,
                timeout_flag: 1'b0,
                timeout_counter_enable: 1'b0,
                tval: rdt_pkg::TVAL_RESET,
                cnt: rdt_pkg::TVAL_RESET,
                byte_seen: 1'b0,
                halted: 1'b0,
                irq_stat: '0,
                irq_mask: rdt_pkg::IRQ_MASK_RESET,
                prdata: 32'h0000_0000
            };
        end
        else
        begin
            s <= next_s;
        end
    end

    // Zero-wait slave: every access completes in its first access cycle
    assign PREADY = 1'b1;
    // Unmapped addresses answer with an error and change nothing
    assign PSLVERR = access && !addr_valid(PADDR);
    assign PRDATA = s.prdata;

    // Status outputs from the state flops; CHANNEL_ACTIVE gates the enable with the halt bit
    assign CHANNEL_ENABLE = s.chan_en;
    assign CHANNEL_ACTIVE = active;
    assign TIMEOUT_FLAG = s.timeout_flag;
    assign OVERRUN_FLAG = s.overrun_flag;
    // Level output: stays high until the status read clears it or a mask write hides it
    assign IRQ = |(s.irq_stat & s.irq_mask);

endmodule

//--- rtl/rdt_pkg.sv
// Package of constants and types for the receive-channel time-out status block
package rdt_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0] ADDR_COUNT = 8'h10;

    // Field positions in rx_dma_timeout_status
    localparam int OVERRUN_BIT = 0;
    localparam int TIMEOUT_BIT = 1;
    localparam int TVAL_LSB = 2;
    localparam int TVAL_MSB = 6;
    localparam int TEN_BIT = 7;

    // Field positions in channel_control_reg
    localparam int IRQ_EN_BIT = 6;
    localparam int CHAN_EN_BIT = 7;

    // Field positions in the interrupt status and mask registers
    localparam int IRQ_STOP_BIT = 0;
    localparam int IRQ_TIMEOUT_BIT = 1;
    localparam int IRQ_OVERRUN_BIT = 2;

    // Field positions in the count register
    localparam int CNT_LSB = 0;
    localparam int CNT_MSB = 4;
    localparam int SEEN_BIT = 8;
    localparam int HALT_BIT = 9;

    // Widths and reset values
    localparam int TVAL_W = 5;
    localparam int IRQ_W = 3;
    localparam logic [TVAL_W-1:0] TVAL_RESET = 5'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [TVAL_W-1:0] CNT_ONE = 5'h01;

    // Start-of-frame period, one step of the down counter
    localparam int SOF_PERIOD_US = 1000;

    // Whole state of the block
    typedef struct packed {
        logic chan_en;
        logic irq_en;
        logic overrun_flag;
        logic timeout_flag;
        logic timeout_counter_enable;
        logic [TVAL_W-1:0] tval;
        logic [TVAL_W-1:0] cnt;
        logic byte_seen;
        logic halted;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
    } rdt_state_t;

endpackage

//--- bench/rdt_far_end.sv
// Far-side model: receiver byte and error pulses, USB frame marker
`timescale 1ns/1ns
module rdt_far_end #(parameter int SOF_CYC = 20000)
(
    input wire logic clk, // System clock
    input wire logic rstn, // Reset, active low
    input wire logic byte_req, // Bench asks for one byte
    input wire logic err_req, // Bench asks for a receive error
    input wire logic full_req, // Bench marks buffers full
    output logic rx_byte, // Byte moved pulse
    output logic sof, // Frame pulse
    output logic rx_err, // Receive error pulse
    output logic full // Buffers and FIFO full
);
    int cnt;
    // Frames run free: the host schedules them whatever the channel does
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 0;
            sof <= 1'b0;
            rx_byte <= 1'b0;
            rx_err <= 1'b0;
            full <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == SOF_CYC - 1) ? 0 : cnt + 1;
            sof <= (cnt == SOF_CYC - 1);
            rx_byte <= byte_req;
            rx_err <= err_req;
            full <= full_req;
        end
    end
endmodule

//--- bench/rdt_timeout_status_chk.sv
// Port checker of the receive time-out status block
`timescale 1ns/1ns
module rdt_chk
(
    input wire logic MCLK, // Clock
    input wire logic RSTN, // Reset, active low
    input wire logic PSEL, // Select
    input wire logic PENABLE, // Access phase
    input wire logic PWRITE, // Write
    input wire logic [7:0] PADDR, // Address
    input wire logic [31:0] PWDATA, // Write data
    input wire logic SOF_PULSE, // Frame pulse
    input wire logic RX_ERROR, // Error pulse
    input wire logic BUFFERS_FULL, // Full level
    input wire logic CHANNEL_ENABLE, // Enable bit
    input wire logic CHANNEL_ACTIVE, // Active
    input wire logic TIMEOUT_FLAG, // Time-out flag
    input wire logic OVERRUN_FLAG // Overrun flag
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    logic wr_st;
    assign wr_st = PSEL && PENABLE && PWRITE && PADDR == rdt_pkg::ADDR_STATUS;
    AST_OVR_CLR: assert property ($fell(OVERRUN_FLAG) |->
        $past(wr_st && PWDATA[0]) || $past(RX_ERROR))
        else $error("overrun flag fell without cause");
    AST_TO_CLR: assert property ($fell(TIMEOUT_FLAG) |->
        $past(wr_st && PWDATA[1]) || $past(RX_ERROR))
        else $error("time-out flag fell without cause");
    AST_TO_SET: assert property ($rose(TIMEOUT_FLAG) |->
        $past(SOF_PULSE) && !CHANNEL_ACTIVE)
        else $error("time-out flag rose without expiry halt");
    AST_OVR_SET: assert property ($rose(OVERRUN_FLAG) |->
        TIMEOUT_FLAG && $past(BUFFERS_FULL && SOF_PULSE))
        else $error("overrun flag rose without full expiry");
    AST_ERR_CLR: assert property (RX_ERROR && CHANNEL_ACTIVE &&
        !SOF_PULSE |=> !TIMEOUT_FLAG && !OVERRUN_FLAG && !CHANNEL_ACTIVE)
        else $error("receive error stop left a flag set");
    AST_ERR_EN: assert property (RX_ERROR && CHANNEL_ACTIVE &&
        !SOF_PULSE && !PSEL |=> CHANNEL_ENABLE)
        else $error("receive error cleared channel enable");
    AST_IDLE: assert property (!CHANNEL_ACTIVE |=>
        !$rose(TIMEOUT_FLAG))
        else $error("time-out while channel inactive");
    AST_STOP_EN: assert property ($fell(CHANNEL_ENABLE) |->
        $past(SOF_PULSE) || $past(PSEL && PWRITE))
        else $error("channel enable fell without cause");
endmodule

bind rdt_timeout_status rdt_chk u_chk (.MCLK(MCLK), .RSTN(RSTN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .SOF_PULSE(SOF_PULSE), .RX_ERROR(RX_ERROR),
    .BUFFERS_FULL(BUFFERS_FULL), .CHANNEL_ENABLE(CHANNEL_ENABLE),
    .CHANNEL_ACTIVE(CHANNEL_ACTIVE), .TIMEOUT_FLAG(TIMEOUT_FLAG),
    .OVERRUN_FLAG(OVERRUN_FLAG));

//--- bench/tb.sv
// Self-checking bench of the receive time-out status block
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
    localparam int SOF = 40;
    logic clk, rstn, psel, penable, pwrite, byte_req, err_req, full_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, rx_byte, sof, rx_err, full;
    logic en, act, tof, ovf, irq, e;
    int n_errors = 0;
    int num_checks = 0;
    int sofs = 0;
    rdt_timeout_status dut (.MCLK(clk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .RX_BYTE_XFER(rx_byte), .SOF_PULSE(sof), .RX_ERROR(rx_err),
        .BUFFERS_FULL(full), .CHANNEL_ENABLE(en), .CHANNEL_ACTIVE(act),
        .TIMEOUT_FLAG(tof), .OVERRUN_FLAG(ovf), .IRQ(irq));
    rdt_far_end #(.SOF_CYC(SOF)) far (.clk(clk), .rstn(rstn),
        .byte_req(byte_req), .err_req(err_req), .full_req(full_req),
        .rx_byte(rx_byte), .sof(sof), .rx_err(rx_err), .full(full));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Frames since the last byte; a byte in the same cycle wins
    always @(posedge clk)
        sofs <= rx_byte ? 0 : (sof ? sofs + 1 : sofs);
    function automatic int exp_sofs(input logic [4:0] t);
        return (t == 5'h00) ? 1 : int'(t);
    endfunction
    function automatic logic [2:0] exp_irq(input logic f, input logic ie);
        return {f, 1'b1, ie};
    endfunction
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Ends at a falling edge so outputs of the last edge have settled
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 50)
        begin
            n_errors++;
            summarize();
        end
        @(negedge clk);
    endtask
    task automatic pulse(input logic err);
        @(posedge clk);
        byte_req <= ~err;
        err_req <= err;
        @(posedge clk);
        byte_req <= 1'b0;
        err_req <= 1'b0;
    endtask
    task automatic scen(input logic [4:0] t, input logic f,
        input logic ie, input logic [2:0] m);
        logic [31:0] cfg;
        int i;
        cfg = {24'h0, 1'b1, t, 2'b00};
        full_req <= f;
        apb(1'b1, rdt_pkg::ADDR_IRQ_MASK, {29'h0, m});
        apb(1'b1, rdt_pkg::ADDR_STATUS, cfg);
        apb(1'b1, rdt_pkg::ADDR_CONTROL, {24'h0, 1'b1, ie, 6'h00});
        pulse(1'b0);
        if (t > 5'h01)
        begin
            repeat (SOF) @(posedge clk);
            pulse(1'b0);
        end
        for (i = 0; i < 2000 && tof !== 1'b1; i++)
            @(posedge clk);
        if (i == 2000)
        begin
            n_errors++;
            summarize();
        end
        // Look between edges, once the expiry edge has settled
        @(negedge clk);
        `CHK("frames", exp_sofs(t), sofs)
        `CHK("overrun", f, ovf)
        `CHK("active", 1'b0, act)
        `CHK("enable", ~ie, en)
        `CHK("irq", |(m & exp_irq(f, ie)), irq)
        apb(1'b0, rdt_pkg::ADDR_IRQ_STATUS, 32'h0);
        `CHK("irq status", exp_irq(f, ie), q[2:0])
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b1, rdt_pkg::ADDR_STATUS, cfg);
        `CHK("flags kept", {1'b1, f}, {tof, ovf})
        apb(1'b1, rdt_pkg::ADDR_STATUS, cfg | 32'h3);
        `CHK("flags cleared", 2'b00, {tof, ovf})
    endtask
    initial
    begin
        {rstn, psel, penable, pwrite, byte_req, err_req, full_req} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(32'h4ba5));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        // Every register reads zero after reset; the last address is unmapped
        for (int a = 0; a < 6; a++)
        begin
            apb(1'b0, 8'(a * 4), 32'h0);
            `CHK("reset value", 32'h0, q)
            `CHK("slave error", a == 5, e)
        end
        scen(5'h00, 1'b0, 1'b0, 3'h7);
        scen(5'h1f, 1'b1, 1'b1, 3'h2);
        repeat (4)
            scen(5'($urandom), 1'($urandom), 1'($urandom),
                3'($urandom));
        apb(1'b1, rdt_pkg::ADDR_STATUS, 32'h08);
        apb(1'b1, rdt_pkg::ADDR_CONTROL, 32'h80);
        pulse(1'b0);
        repeat (4 * SOF) @(posedge clk);
        apb(1'b0, rdt_pkg::ADDR_COUNT, 32'h0);
        `CHK("count held", 32'h102, q)
        `CHK("no time-out", 1'b0, tof)
        apb(1'b1, rdt_pkg::ADDR_CONTROL, 32'h80);
        apb(1'b1, rdt_pkg::ADDR_STATUS, 32'h84);
        repeat (3 * SOF) @(posedge clk);
        `CHK("no byte yet", 1'b0, tof)
        pulse(1'b1);
        repeat (2) @(negedge clk);
        `CHK("error stop", 4'b0001, {tof, ovf, act, en})
        apb(1'b0, rdt_pkg::ADDR_IRQ_STATUS, 32'h0);
        `CHK("error irq", 3'h0, q[2:0])
        summarize();
    end
endmodule
